// File: ssbp_consts.vh
`ifndef SSBP_CONSTS_VH
`define SSBP_CONSTS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define SSBP_IDX_BUF_FIRST   12'hf90
`define SSBP_IDX_BUF_LAST    12'hf97
`define SSBP_IDX_MAIN_CTRL   12'hf98
`define SSBP_IDX_BURST_STAT  12'hf99
`define SSBP_IDX_CLK_OPT     12'hf9a

// ----------------------------------------
// Main control register fields
// ----------------------------------------
`define SSBP_CTRL_RUN        7
`define SSBP_CTRL_ABORT      6
`define SSBP_CTRL_MODE_HI    5
`define SSBP_CTRL_MODE_LO    3
`define SSBP_CTRL_CLK_HI     2
`define SSBP_CTRL_CLK_LO     0

// ----------------------------------------
// Burst config fields and status bits
// ----------------------------------------
`define SSBP_CFG_WAIT_HI     4
`define SSBP_CFG_WAIT_LO     3
`define SSBP_CFG_CNT_HI      2
`define SSBP_CFG_CNT_LO      0
`define SSBP_STAT_XFER       7
`define SSBP_STAT_SHIFT      6

// ----------------------------------------
// Clock option register bits
// ----------------------------------------
`define SSBP_OPT_PRESC       0
`define SSBP_OPT_SLOW        1

// ----------------------------------------
// Transfer modes and clock codes
// ----------------------------------------
`define SSBP_MODE_TX8        3'h0
`define SSBP_MODE_TX4        3'h2
`define SSBP_MODE_DUP8       3'h4
`define SSBP_MODE_RX8        3'h5
`define SSBP_MODE_RX4        3'h6
`define SSBP_CLK_EXT         3'h7

// ----------------------------------------
// Half-period lengths minus one, in pclk cycles or low-freq ticks
// ----------------------------------------
`define SSBP_HALF_DIV13      12'hfff
`define SSBP_HALF_LF5        12'h00f
`define SSBP_HALF_DIV8       12'h07f
`define SSBP_HALF_DIV7       12'h03f
`define SSBP_HALF_DIV6       12'h01f
`define SSBP_HALF_DIV5       12'h00f
`define SSBP_HALF_DIV4       12'h007

`endif

// File: ssbp_port.v
// Summary of operation
// RQ1: Wait code sets frame as 1/2/4/8 word times
// RQ2: Burst length is word count code plus one
// RQ3: 4-bit words use low nibble, upper cleared
// RQ4: Buffer used from lowest entry upward
// RQ5: Word count kept after a burst ends
// RQ6: Software writes burst config only when idle
// RQ7: Burst config is write-only, no read-modify-write
// RQ8: Status bit 7 shows transfer in process
// RQ9: Status bit 6 shows shift in progress
// RQ10: Run cleared ends at word end; abort immediately
// RQ11: Internal clock driven out, high at start
// RQ12: Clock code picks six rates or external
// RQ13: Internal clock waits for buffer service
// RQ14: External clock pulses four cycles wide minimum
// RQ15: Transmit data changes on clock falling edge
// RQ16: Receive data sampled on clock rising edge
// RQ17: Words go least significant bit first
// RQ18: Done pulse after programmed word count transferred
// RQ19: Stop port before changing count, except waiting
// RQ20: Mode field selects five transfer modes
// RQ21: Run starts/stops; abort aborts and self-clears
// RQ22: External clock synchronised and edge detected
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "ssbp_consts.vh"

module ssbp_port
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        lf_tick,
    input  wire        sck_in,
    output reg         sck_out,
    output reg         sck_oe_n,
    output reg         sdo,
    input  wire        sdi,
    output reg         transfer_done
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;
    localparam [1:0] ST_GAP   = 2'h2;
    localparam [1:0] ST_AWAIT = 2'h3;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg  [7:0]  dbuf [0:7];
    reg         run_bit;
    reg         abort_bit;
    reg  [2:0]  transfer_mode_field;
    reg  [2:0]  clk_sel;
    reg  [1:0]  wait_field;
    reg  [2:0]  word_cnt;
    reg         prescaler_select_bit;
    reg         slow_mode;
    reg  [1:0]  state;
    reg         transfer_active_flag;
    reg  [2:0]  word_idx;
    reg  [2:0]  bit_cnt;
    reg  [7:0]  shreg;
    reg  [6:0]  gap_cnt;
    reg         svc_pending;
    reg  [11:0] half_cnt;
    reg         half_tick;
    reg         sck_meta;
    reg         sck_sync;
    reg         sck_last;
    integer     i;

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    function addr_ok;
        input [15:0] a;
        begin
            addr_ok = (a[1:0] == 2'h0) && (a[15:14] == 2'h0);
        end
    endfunction

    // Half period length per clock code [RQ12]
    function [11:0] half_len;
        input [2:0] sel;
        input       lf;
        begin
            case (sel)
                3'h0:    half_len = lf ? `SSBP_HALF_LF5 : `SSBP_HALF_DIV13;
                3'h1:    half_len = `SSBP_HALF_DIV8;
                3'h2:    half_len = `SSBP_HALF_DIV7;
                3'h3:    half_len = `SSBP_HALF_DIV6;
                3'h4:    half_len = `SSBP_HALF_DIV5;
                default: half_len = `SSBP_HALF_DIV4;
            endcase
        end
    endfunction

    wire [11:0] reg_idx   = paddr[13:2];
    wire        acc       = psel && penable && pready;
    wire        wr_hit    = acc && pwrite && addr_ok(paddr);
    wire        rd_hit    = acc && !pwrite && addr_ok(paddr);
    wire        is_buf    = (reg_idx >= `SSBP_IDX_BUF_FIRST) && (reg_idx <= `SSBP_IDX_BUF_LAST);
    wire        wr_buf    = wr_hit && is_buf;
    wire        rd_buf    = rd_hit && is_buf;
    wire [2:0]  buf_sel   = reg_idx[2:0];
    wire        use_lf    = prescaler_select_bit || slow_mode;
    wire        internal  = (clk_sel != `SSBP_CLK_EXT);
    wire        nib_mode  = (transfer_mode_field == `SSBP_MODE_TX4) || (transfer_mode_field == `SSBP_MODE_RX4);
    wire        rx_only   = (transfer_mode_field == `SSBP_MODE_RX8) || (transfer_mode_field == `SSBP_MODE_RX4);
    wire        stores    = rx_only || (transfer_mode_field == `SSBP_MODE_DUP8);
    wire        mode_ok   = (transfer_mode_field == `SSBP_MODE_TX8) || nib_mode || stores;
    wire        clk_ok    = (clk_sel != 3'h6);
    wire [2:0]  last_bit  = nib_mode ? 3'h3 : 3'h7;
    wire        ext_fall  = sck_last && !sck_sync;
    wire        ext_rise  = !sck_last && sck_sync;
    wire        ev_fall   = internal ? (half_tick && sck_out) : ext_fall;
    wire        ev_rise   = internal ? (half_tick && !sck_out) : ext_rise;
    wire [2:0]  next_idx  = word_idx + 3'h1;
    wire [7:0]  rx_word   = nib_mode ? {4'h0, sdi, shreg[3:1]} : {sdi, shreg[7:1]};
    wire [6:0]  frame_mul = (7'h1 << wait_field) - 7'h1;
    wire [6:0]  gap_len   = nib_mode ? {frame_mul[3:0], 3'h0} : {frame_mul[2:0], 4'h0};

    // ----------------------------------------
    // External clock synchroniser
    // ----------------------------------------
    // Two-flop sync then edge detect on the second stage [RQ22]
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_meta <= 1'b1;
            sck_sync <= 1'b1;
            sck_last <= 1'b1;
        end
        else
        begin
            sck_meta <= sck_in;
            sck_sync <= sck_meta;
            sck_last <= sck_sync;
        end
    end

    // ----------------------------------------
    // Internal rate generator
    // ----------------------------------------
    // Half-period tick, counts low-freq ticks for clock code 0 in prescaler or slow mode [RQ12]
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_cnt  <= 12'h000;
            half_tick <= 1'b0;
        end
        else
        begin
            half_tick <= 1'b0;
            if (state == ST_IDLE)
                half_cnt <= half_len(clk_sel, use_lf);
            else if (!(clk_sel == 3'h0 && use_lf) || lf_tick)
            begin
                if (half_cnt == 12'h000)
                begin
                    half_cnt  <= half_len(clk_sel, use_lf);
                    half_tick <= 1'b1;
                end
                else
                    half_cnt <= half_cnt - 12'h001;
            end
        end
    end

    // ----------------------------------------
    // APB response
    // ----------------------------------------
    // One wait state; data and error captured with pready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && penable && !pready)
            begin
                if (!addr_ok(paddr))
                    pslverr <= 1'b1;
                else if (is_buf)
                    prdata <= {24'h000000, dbuf[buf_sel]};
                else if (reg_idx == `SSBP_IDX_BURST_STAT)
                    prdata <= {24'h000000, transfer_active_flag, (state == ST_SHIFT), 6'h00}; // [RQ8] [RQ9]
                else if (reg_idx == `SSBP_IDX_CLK_OPT)
                    prdata <= {30'h00000000, slow_mode, prescaler_select_bit};
                else if (reg_idx != `SSBP_IDX_MAIN_CTRL)
                    pslverr <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Registers and transfer engine
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (i = 0; i < 8; i = i + 1)
                dbuf[i] <= 8'h00;
            run_bit              <= 1'b0;
            abort_bit            <= 1'b0;
            transfer_mode_field  <= 3'h0;
            clk_sel              <= 3'h0;
            wait_field           <= 2'h0;
            word_cnt             <= 3'h0;
            prescaler_select_bit <= 1'b0;
            slow_mode            <= 1'b0;
            state                <= ST_IDLE;
            transfer_active_flag <= 1'b0;
            word_idx             <= 3'h0;
            bit_cnt              <= 3'h0;
            shreg                <= 8'h00;
            gap_cnt              <= 7'h00;
            svc_pending          <= 1'b0;
            sck_out              <= 1'b1;
            sck_oe_n             <= 1'b1;
            sdo                  <= 1'b1;
            transfer_done        <= 1'b0;
        end
        else
        begin
            transfer_done <= 1'b0;
            sck_oe_n      <= !internal;   // Drive pin only on internal clock [RQ11]
            // Software writes; abort lives one cycle [RQ21]
            if (wr_hit && reg_idx == `SSBP_IDX_MAIN_CTRL)
            begin
                run_bit             <= pwdata[`SSBP_CTRL_RUN];
                abort_bit           <= pwdata[`SSBP_CTRL_ABORT];
                transfer_mode_field <= pwdata[`SSBP_CTRL_MODE_HI:`SSBP_CTRL_MODE_LO]; // [RQ20]
                clk_sel             <= pwdata[`SSBP_CTRL_CLK_HI:`SSBP_CTRL_CLK_LO];
            end
            else
                abort_bit <= 1'b0; // [RQ21]
            // Count is only changed by software, never by a burst [RQ5]
            if (wr_hit && reg_idx == `SSBP_IDX_BURST_STAT)
            begin
                wait_field <= pwdata[`SSBP_CFG_WAIT_HI:`SSBP_CFG_WAIT_LO];
                word_cnt   <= pwdata[`SSBP_CFG_CNT_HI:`SSBP_CFG_CNT_LO];
            end
            if (wr_hit && reg_idx == `SSBP_IDX_CLK_OPT)
            begin
                prescaler_select_bit <= pwdata[`SSBP_OPT_PRESC];
                slow_mode            <= pwdata[`SSBP_OPT_SLOW];
            end
            if (wr_buf)
                dbuf[buf_sel] <= pwdata[7:0];
            // Service access releases the automatic wait [RQ13]
            if ((wr_buf && !rx_only) || (rd_buf && rx_only))
                svc_pending <= 1'b0;

            if (abort_bit)
            begin
                // Immediate stop [RQ10]
                state                <= ST_IDLE;
                transfer_active_flag <= 1'b0;
                sck_out              <= 1'b1;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (run_bit && mode_ok && clk_ok)
                        begin
                            state                <= ST_SHIFT;
                            transfer_active_flag <= 1'b1;              // [RQ8]
                            sck_out              <= 1'b1;              // [RQ11]
                            word_idx             <= 3'h0;              // [RQ4]
                            bit_cnt              <= 3'h0;
                            svc_pending          <= 1'b0;              // No stale wait from last run
                            shreg                <= nib_mode ? {4'h0, dbuf[0][3:0]} : dbuf[0]; // [RQ3]
                        end
                    end
                    ST_SHIFT:
                    begin
                        if (ev_fall)
                        begin
                            // Leading edge moves out the low bit [RQ15] [RQ17]
                            if (internal)
                                sck_out <= 1'b0;
                            sdo <= shreg[0];
                        end
                        else if (ev_rise)
                        begin
                            // Trailing edge samples into the top [RQ16] [RQ17]
                            if (internal)
                                sck_out <= 1'b1;
                            shreg   <= rx_word;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == last_bit)
                            begin
                                bit_cnt <= 3'h0;
                                if (stores)
                                    dbuf[word_idx] <= rx_word;                 // [RQ3] [RQ4]
                                if (word_idx == word_cnt)
                                begin
                                    transfer_done <= 1'b1;                     // [RQ18]
                                    svc_pending   <= 1'b1;
                                    word_idx      <= 3'h0;                     // [RQ2]
                                    if (!run_bit || (!internal && rx_only && svc_pending))
                                    begin
                                        state                <= ST_IDLE;      // [RQ10]
                                        transfer_active_flag <= 1'b0;
                                    end
                                    else if (internal)
                                        state <= ST_AWAIT;                    // [RQ13]
                                    else
                                        shreg <= nib_mode ? {4'h0, dbuf[0][3:0]} : dbuf[0];
                                end
                                else if (!run_bit)
                                begin
                                    state                <= ST_IDLE;          // [RQ10]
                                    transfer_active_flag <= 1'b0;
                                end
                                else
                                begin
                                    word_idx <= next_idx;                     // [RQ2] [RQ4]
                                    shreg    <= nib_mode ? {4'h0, dbuf[next_idx][3:0]} : dbuf[next_idx];
                                    if (internal && wait_field != 2'h0)
                                    begin
                                        state   <= ST_GAP;                    // [RQ1]
                                        gap_cnt <= gap_len;
                                    end
                                end
                            end
                        end
                    end
                    ST_GAP:
                    begin
                        // Clock held high for the extra frame time [RQ1]
                        if (half_tick)
                        begin
                            if (gap_cnt == 7'h01)
                                state <= ST_SHIFT;
                            gap_cnt <= gap_cnt - 7'h01;
                        end
                    end
                    ST_AWAIT:
                    begin
                        // Clock stopped until buffer serviced [RQ13]
                        if (!run_bit)
                        begin
                            state                <= ST_IDLE;
                            transfer_active_flag <= 1'b0;
                        end
                        else if (!svc_pending)
                        begin
                            state <= ST_SHIFT;
                            shreg <= nib_mode ? {4'h0, dbuf[0][3:0]} : dbuf[0];
                        end
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule

// File: ssbp_port_monitor.sv
`timescale 1ns/1ps
`include "ssbp_consts.vh"
module ssbp_monitor
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        lf_tick,
    input wire logic        sck_in,
    input wire logic        sck_out,
    input wire logic        sck_oe_n,
    input wire logic        sdo,
    input wire logic        sdi,
    input wire logic        transfer_done
);
    localparam logic [15:0] STAT_ADDR = {2'b00, `SSBP_IDX_BURST_STAT, 2'b00};
    logic stat_rd;

    // Completed status read
    assign stat_rd = psel && penable && pready && !pwrite && (paddr == STAT_ADDR);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Bus and status checks
    // ----------------------------------------
    chk_ready_once: assert property (pready |=> !pready)
        else $error("pready high two cycles");
    chk_slverr_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_status_pad: assert property (stat_rd |-> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h0)
        else $error("status unused bits set");
    chk_shift_flag: assert property (stat_rd && !sck_oe_n && !$past(sck_out) && !$past(sck_out, 2) |-> prdata[6])
        else $error("shift flag low while shifting");

    // ----------------------------------------
    // Serial clock and data checks
    // ----------------------------------------
    chk_oe_high_start: assert property (!sck_oe_n && $past(sck_oe_n) |-> sck_out)
        else $error("clock pin not high when driven");
    chk_sdo_on_fall: assert property ($changed(sdo) && !sck_oe_n && !$past(sck_oe_n) |-> $fell(sck_out))
        else $error("data changed off falling clock");
    chk_fast_half: assert property ($fell(sck_out) && !sck_oe_n |-> !sck_out [*8])
        else $error("clock low phase too short");
    chk_done_high: assert property (transfer_done && !sck_oe_n |-> sck_out)
        else $error("burst end with clock low");
    chk_done_single: assert property (transfer_done |=> !transfer_done [*8])
        else $error("done pulse repeated");

    cov_done_int: cover property (transfer_done && !sck_oe_n);
    cov_done_ext: cover property (transfer_done && sck_oe_n);
    cov_slverr: cover property (pslverr);
endmodule

bind ssbp_port ssbp_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lf_tick(lf_tick), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo(sdo), .sdi(sdi),
    .transfer_done(transfer_done));

// File: ssbp_peer.sv
`timescale 1ns/1ps
module ssbp_peer
(
    input  wire logic        pclk,
    input  wire logic        clr,
    input  wire logic        ext_run,
    input  wire logic [63:0] tx_bits,
    input  wire logic        sck_out,
    input  wire logic        sck_oe_n,
    input  wire logic        sdo,
    output logic             sck_in,
    output logic             sdi,
    output logic [63:0]      rx_bits,
    output int               rise_cnt
);
    logic       pin;
    logic       pin_q;
    logic [2:0] div;
    logic [5:0] bit_idx;

    // Clock pin level, pulled high when nobody clocks it
    assign pin = sck_oe_n ? sck_in : sck_out;

    // External clock with 8-cycle halves
    always @(posedge pclk)
    begin
        if (!ext_run)
        begin
            sck_in <= 1'b1;
            div    <= 3'h0;
        end
        else
        begin
            div <= div + 3'h1;
            if (div == 3'h7)
                sck_in <= ~sck_in;
        end
    end

    // Capture device data on rise, present own data after fall
    always @(posedge pclk)
    begin
        pin_q <= pin;
        if (clr)
        begin
            rise_cnt <= 0;
            bit_idx  <= 6'h0;
            rx_bits  <= 64'h0;
            sdi      <= 1'b1;
        end
        else if (pin && !pin_q)
        begin
            rx_bits  <= {sdo, rx_bits[63:1]};
            rise_cnt <= rise_cnt + 1;
        end
        else if (!pin && pin_q)
        begin
            sdi     <= tx_bits[bit_idx];
            bit_idx <= bit_idx + 6'h1;
        end
    end
endmodule

// File: test_sync_serial_buffered_port.sv
`timescale 1ns/1ps
`include "ssbp_consts.vh"
module test_sync_serial_buffered_port;
    logic        pclk, presetn, psel, penable, pwrite, lf_tick, sck_in, sdi, ext_run, clr;
    logic        pready, pslverr, sck_out, sck_oe_n, sdo, transfer_done, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [63:0] tx_bits, rx_bits;
    logic [7:0]  rd;
    int          rise_cnt, err_count, n_compared;
    int          done_cnt = 0;

    ssbp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lf_tick(lf_tick), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo(sdo),
        .sdi(sdi), .transfer_done(transfer_done));
    ssbp_peer peer (.pclk(pclk), .clr(clr), .ext_run(ext_run), .tx_bits(tx_bits), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .sdo(sdo), .sck_in(sck_in), .sdi(sdi), .rx_bits(rx_bits), .rise_cnt(rise_cnt));

    // Clock and burst-end counter
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (transfer_done === 1'b1)
            done_cnt <= done_cnt + 1;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task fail(input string what);
        err_count++;
        $display("unexpected at %0t: %s timed out", $time, what);
        end_of_test;
    endtask

    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            fail("pready");
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_done(input int want);
        int n;
        n = 0;
        while (done_cnt < want && n < 3000)
        begin
            apb(1'b0, `SSBP_IDX_BURST_STAT, 8'h00);
            n++;
        end
        if (done_cnt < want)
            fail("burst end");
    endtask

    task peer_clear;
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
    endtask

    task abort_idle(input logic [7:0] ctrl);
        apb(1'b1, `SSBP_IDX_MAIN_CTRL, ctrl);
        repeat (3) @(posedge pclk);
        apb(1'b0, `SSBP_IDX_BURST_STAT, 8'h00);
        check(rd, 8'h00, "status after abort");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        apb(1'b0, `SSBP_IDX_BURST_STAT, 8'h00);
        check(rd, 8'h00, "status at reset");
        apb(1'b1, `SSBP_IDX_BUF_LAST, 8'h5a);
        apb(1'b0, `SSBP_IDX_BUF_LAST, 8'h00);
        check(rd, 8'h5a, "buffer readback");
        apb(1'b1, 12'hf9b, 8'h11);
        check({7'h0, err}, 8'h01, "unmapped error");
        apb(1'b1, `SSBP_IDX_MAIN_CTRL, 8'h8d);
        abort_idle(8'h0d);
        apb(1'b1, `SSBP_IDX_MAIN_CTRL, 8'h86);
        abort_idle(8'h06);
        $display("registers test done");
    endtask

    task t_tx8_int;
        int d0;
        d0 = done_cnt;
        apb(1'b1, `SSBP_IDX_BUF_FIRST, 8'ha5);
        apb(1'b1, `SSBP_IDX_BURST_STAT, 8'h00);
        peer_clear;
        apb(1'b1, `SSBP_IDX_MAIN_CTRL, 8'h85);
        wait_done(d0 + 1);
        check(rx_bits[63:56], 8'ha5, "sent byte");
        repeat (200) @(posedge pclk);
        check(rise_cnt[7:0], 8'h08, "clock stopped in wait");
        apb(1'b0, `SSBP_IDX_BURST_STAT, 8'h00);
        check(rd & 8'h80, 8'h80, "active in wait");
        abort_idle(8'h45);
        $display("internal transmit test done");
    endtask

    task t_rx4_int;
        int d0;
        d0 = done_cnt;
        apb(1'b1, `SSBP_IDX_BURST_STAT, 8'h02);
        tx_bits <= 64'hc96;
        peer_clear;
        apb(1'b1, `SSBP_IDX_MAIN_CTRL, 8'hb5);
        wait_done(d0 + 1);
        check(rise_cnt[7:0], 8'h0c, "rises in burst");
        peer_clear;
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b0, `SSBP_IDX_BUF_FIRST + 12'(k), 8'h00);
            check(rd, {4'h0, tx_bits[4*k +: 4]}, "nibble stored");
        end
        wait_done(d0 + 2);
        check(rise_cnt[7:0], 8'h0c, "count kept");
        abort_idle(8'h75);
        $display("internal receive test done");
    endtask

    task t_ext_tx8;
        int d0;
        int n;
        d0 = done_cnt;
        apb(1'b1, `SSBP_IDX_BUF_FIRST, 8'h3c);
        apb(1'b1, `SSBP_IDX_BURST_STAT, 8'h00);
        peer_clear;
        apb(1'b1, `SSBP_IDX_MAIN_CTRL, 8'h87);
        repeat (2) @(posedge pclk);
        check({7'h0, sck_oe_n}, 8'h01, "clock pin released");
        ext_run <= 1'b1;
        n = 0;
        while (rise_cnt < 8 && n < 1000)
        begin
            @(posedge pclk);
            n++;
        end
        ext_run <= 1'b0;
        if (rise_cnt < 8)
            fail("external clock");
        wait_done(d0 + 1);
        check(rx_bits[63:56], 8'h3c, "external byte");
        abort_idle(8'h47);
        $display("external transmit test done");
    endtask

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        lf_tick = 1'b0;
        ext_run = 1'b0;
        clr = 1'b1;
        tx_bits = 64'h0;
        err_count = 0;
        n_compared = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        clr <= 1'b0;
        t_regs;
        t_tx8_int;
        t_rx4_int;
        t_ext_tx8;
        end_of_test;
    end
endmodule
